// [include/nfhc_consts.svh]
// Timing and layout constants for the NOR flash host controller
`ifndef NFHC_CONSTS_SVH
`define NFHC_CONSTS_SVH
`define NFHC_CLK_NS            100
`define NFHC_RANDOM_ACCESS_NS  110
`define NFHC_PAGE_ACCESS_NS    25
`define NFHC_SETUP_NS          10
`define NFHC_WE_LOW_NS         50
`define NFHC_WE_HIGH_NS        30
`define NFHC_RESET_LOW_NS      50000
`define NFHC_RESET_READ_NS     50000
`define NFHC_RESET_WRITE_NS    50000
`define NFHC_RESET_ABORT_NS    30000
`define NFHC_BLOCK_SHIFT       16
`define NFHC_PAGE_BITS         4
`endif

// [include/nfhc_pkg.sv]
// Types shared by the NOR flash host controller
package nfhc_pkg;
   typedef enum logic [1:0] {
      NFHC_OP_READ,
      NFHC_OP_WRITE,
      NFHC_OP_RESET
   } nfhc_op_t;

   typedef struct packed {
      nfhc_op_t    op;
      logic [26:0] addr;
      logic [15:0] wdata;
   } nfhc_req_t;

   typedef struct packed {
      logic [26:0] addr;
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
      logic        rst_n;
      logic        wp_n;
   } nfhc_pins_t;
endpackage

// [src/nfhc_host.sv]
// Host-side controller that drives the NOR flash asynchronous bus pins
// Notes on behaviour
// - Read: address out, select and output enable low, write strobe and reset high.
// - Write: select and strobe low, output enable high, reset and protect high; the host drives protect from wr_protect_i, not forced high.
// - Select toggled between reads forces a full random access time.
// - Host holds output enable high throughout every write cycle.
// - After reset release wait reset-to-read and reset-to-write delays.
// - Host tracks operations with one status method only.
`timescale 1ns/1ps
`include "nfhc_consts.svh"
module nfhc_host #(
   parameter int ADDR_W      = 27,
   parameter int DATA_W      = 16,
   parameter int RST_LOW_CYC = (`NFHC_RESET_LOW_NS + `NFHC_CLK_NS - 1) / `NFHC_CLK_NS,
   parameter int RST_RD_CYC  = (`NFHC_RESET_READ_NS + `NFHC_CLK_NS - 1) / `NFHC_CLK_NS,
   parameter int RST_WR_CYC  = (`NFHC_RESET_WRITE_NS + `NFHC_CLK_NS - 1) / `NFHC_CLK_NS
) (
   input  wire logic                clk_i,
   input  wire logic                sys_rst_i,
   input  wire logic                clk_en_i,
   input  wire nfhc_pkg::nfhc_req_t req_i,
   input  wire logic                req_valid_i,
   output logic                     req_ready_o,
   output logic [DATA_W-1:0]        rdata_o,
   output logic                     rdata_valid_o,
   input  wire logic                wr_protect_i,
   output logic                     flash_busy_o,
   output nfhc_pkg::nfhc_pins_t     pins_o,
   input  wire logic [DATA_W-1:0]   dq_i,
   output logic [DATA_W-1:0]        dq_o,
   output logic                     dq_oe_o,
   input  wire logic                ready_busy_n_i
);
   // Select falls a cycle after the request, then the data crosses two flops
   localparam int RACC_CYC = (`NFHC_RANDOM_ACCESS_NS + `NFHC_CLK_NS - 1) / `NFHC_CLK_NS + 2;
   localparam int PACC_CYC = (`NFHC_PAGE_ACCESS_NS + `NFHC_CLK_NS - 1) / `NFHC_CLK_NS + 1;
   localparam int WLOW_CYC = (`NFHC_WE_LOW_NS + `NFHC_CLK_NS - 1) / `NFHC_CLK_NS;
   localparam int WHI_CYC  = (`NFHC_WE_HIGH_NS + `NFHC_CLK_NS - 1) / `NFHC_CLK_NS;
   localparam int ABRT_CYC = (`NFHC_RESET_ABORT_NS + `NFHC_CLK_NS - 1) / `NFHC_CLK_NS;
   localparam int CNT_W    = 20;

   // Refuse sizes and counts that the sequencer cannot serve
   if (ADDR_W != 27 || DATA_W != 16) begin : g_chk_width
      $error("nfhc_host: address must be 27 bits and data 16 bits");
   end
   if (RST_LOW_CYC < ABRT_CYC || RST_RD_CYC < 1 || RST_WR_CYC < 1) begin : g_chk_reset
      $error("nfhc_host: reset counts out of range");
   end
   if (RST_LOW_CYC >= (1 << CNT_W) || RST_RD_CYC >= (1 << CNT_W) ||
       RST_WR_CYC >= (1 << CNT_W)) begin : g_chk_cnt
      $error("nfhc_host: reset counts exceed counter width");
   end

   typedef enum logic [2:0] {
      ST_RESET,
      ST_WAKE,
      ST_IDLE,
      ST_READ,
      ST_WR_SETUP,
      ST_WR_LOW,
      ST_WR_HIGH
   } nfhc_state_t;

   // Shared cycle count conversion for unsigned compares
   function automatic logic [CNT_W-1:0] cyc(input int n);
      cyc = CNT_W'(n);
   endfunction

   nfhc_state_t         state_r;
   logic [CNT_W-1:0]    cnt_r;
   logic [CNT_W-1:0]    wake_r;
   logic [ADDR_W-1:0]   addr_r;
   logic [DATA_W-1:0]   wdata_r;
   logic                ce_n_r;
   logic                oe_n_r;
   logic                we_n_r;
   logic                rst_n_r;
   logic                page_ok_r;
   logic [DATA_W-1:0]   rdata_r;
   logic                rvalid_r;
   logic [DATA_W-1:0]   dq_s1_r;
   logic [DATA_W-1:0]   dq_s2_r;
   logic [1:0]          rb_sync_r;
   logic                wp_r;
   logic                same_page;
   logic                is_read;
   logic                is_write;
   logic                is_reset;

   // Pins from outside pass two flops before use
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         dq_s1_r   <= 16'h0000;
         dq_s2_r   <= 16'h0000;
         rb_sync_r <= 2'b11;
      end else if (clk_en_i) begin
         dq_s1_r   <= dq_i;
         dq_s2_r   <= dq_s1_r;
         rb_sync_r <= {rb_sync_r[0], ready_busy_n_i};
      end
   end

   assign flash_busy_o = ~rb_sync_r[1];
   assign is_read      = req_i.op == nfhc_pkg::NFHC_OP_READ;
   assign is_write     = req_i.op == nfhc_pkg::NFHC_OP_WRITE;
   assign is_reset     = req_i.op == nfhc_pkg::NFHC_OP_RESET;
   // Page hit: same address above the in-page word index, select still low
   assign same_page = page_ok_r &&
      (req_i.addr[ADDR_W-1:`NFHC_PAGE_BITS] == addr_r[ADDR_W-1:`NFHC_PAGE_BITS]);
   // Writes wait for the write wake-up; reset requests are taken in idle whenever clk_en_i is high
   assign req_ready_o = (state_r == ST_IDLE) && clk_en_i &&
      (!is_write || wake_r >= cyc(RST_WR_CYC));

   // Main sequencer
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_r   <= ST_RESET;
         cnt_r     <= 20'h00000;
         addr_r    <= 27'h0000000;
         wdata_r   <= 16'h0000;
         ce_n_r    <= 1'b1;
         oe_n_r    <= 1'b1;
         we_n_r    <= 1'b1;
         rst_n_r   <= 1'b0;
         page_ok_r <= 1'b0;
         rdata_r   <= 16'h0000;
         rvalid_r  <= 1'b0;
         wp_r      <= 1'b0;
      end else if (clk_en_i) begin
         rvalid_r <= 1'b0;
         wp_r     <= wr_protect_i;
         case (state_r)
            // Reset held long enough to also cover an operation abort
            ST_RESET: begin
               ce_n_r    <= 1'b1;
               oe_n_r    <= 1'b1;
               we_n_r    <= 1'b1;
               rst_n_r   <= 1'b0;
               page_ok_r <= 1'b0;
               cnt_r     <= cnt_r + 20'h00001;
               if (cnt_r >= cyc(RST_LOW_CYC) - 20'h00001) begin
                  rst_n_r <= 1'b1;
                  cnt_r   <= 20'h00000;
                  state_r <= ST_WAKE;
               end
            end
            // Read wake-up must elapse before any access
            ST_WAKE: begin
               cnt_r <= cnt_r + 20'h00001;
               if (cnt_r >= cyc(RST_RD_CYC) - 20'h00001) begin
                  cnt_r   <= 20'h00000;
                  state_r <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               if (req_valid_i && req_ready_o) begin
                  addr_r  <= req_i.addr;
                  wdata_r <= req_i.wdata;
                  cnt_r   <= 20'h00000;
                  if (is_reset) begin
                     state_r <= ST_RESET;
                  end else if (is_read) begin
                     // Page hit keeps select low; otherwise full random access
                     if (!same_page) begin
                        ce_n_r    <= 1'b1;
                        page_ok_r <= 1'b0;
                     end
                     // Only requested cycles go out, so one status method is never mixed
                     state_r <= ST_READ;
                  end else begin
                     ce_n_r  <= 1'b1;
                     oe_n_r  <= 1'b1;
                     state_r <= ST_WR_SETUP;
                  end
               end
            end
            ST_READ: begin
               ce_n_r <= 1'b0;
               oe_n_r <= 1'b0;
               we_n_r <= 1'b1;
               cnt_r  <= cnt_r + 20'h00001;
               // Random access time applies unless the page stays open
               if (cnt_r >= (page_ok_r ? cyc(PACC_CYC) : cyc(RACC_CYC))) begin
                  rdata_r   <= dq_s2_r;
                  rvalid_r  <= 1'b1;
                  // Output enable stays low so a page hit sees data as the address moves
                  page_ok_r <= 1'b1;
                  cnt_r     <= 20'h00000;
                  state_r   <= ST_IDLE;
               end
            end
            // Address settles before select and strobe fall together
            ST_WR_SETUP: begin
               page_ok_r <= 1'b0;
               oe_n_r    <= 1'b1;
               ce_n_r    <= 1'b0;
               we_n_r    <= 1'b0;
               state_r   <= ST_WR_LOW;
            end
            // Strobe rises first so the data edge is unambiguous
            ST_WR_LOW: begin
               cnt_r <= cnt_r + 20'h00001;
               if (cnt_r >= cyc(WLOW_CYC) - 20'h00001) begin
                  we_n_r  <= 1'b1;
                  cnt_r   <= 20'h00000;
                  state_r <= ST_WR_HIGH;
               end
            end
            ST_WR_HIGH: begin
               ce_n_r <= 1'b1;
               cnt_r  <= cnt_r + 20'h00001;
               if (cnt_r >= cyc(WHI_CYC) - 20'h00001) begin
                  cnt_r   <= 20'h00000;
                  state_r <= ST_IDLE;
               end
            end
            default: state_r <= ST_RESET;
         endcase
      end
   end

   // Time since reset release, saturating; gates the first write
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wake_r <= 20'h00000;
      end else if (clk_en_i) begin
         if (!rst_n_r) begin
            wake_r <= 20'h00000;
         end else if (wake_r < cyc(RST_WR_CYC)) begin
            wake_r <= wake_r + 20'h00001;
         end
      end
   end

   // Data drive only while writing; output enable high there, so no contention
   assign dq_o    = wdata_r;
   assign dq_oe_o = (state_r == ST_WR_LOW) || (state_r == ST_WR_HIGH && !ce_n_r);
   assign rdata_o       = rdata_r;
   assign rdata_valid_o = rvalid_r;
   assign pins_o.addr   = addr_r;
   assign pins_o.ce_n   = ce_n_r;
   assign pins_o.oe_n   = oe_n_r;
   assign pins_o.we_n   = we_n_r;
   assign pins_o.rst_n  = rst_n_r;
   assign pins_o.wp_n   = ~wp_r;
endmodule

// [verif/nfhc_host_props.sv]
// Pin protocol checker for the NOR flash host controller
`timescale 1ns/1ps
module nfhc_host_props #(
   parameter int DATA_W = 16
) (
   input  wire logic                 clk_i,
   input  wire logic                 sys_rst_i,
   input  wire logic                 req_ready_o,
   input  wire logic                 rdata_valid_o,
   input  wire logic                 wr_protect_i,
   input  wire nfhc_pkg::nfhc_pins_t pins_o,
   input  wire logic [DATA_W-1:0]    dq_o,
   input  wire logic                 dq_oe_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // Reads never overlap a host drive of the data pins
   a_read_strobes: assert property (
      !pins_o.oe_n |-> pins_o.we_n && pins_o.rst_n && !dq_oe_o) else $error("bad read strobes");
   a_write_oe_high: assert property (
      !pins_o.we_n |-> pins_o.oe_n && !pins_o.ce_n && dq_oe_o) else $error("bad write strobes");
   a_reset_quiet: assert property (
      !pins_o.rst_n |-> pins_o.ce_n && pins_o.oe_n && pins_o.we_n && !dq_oe_o && !req_ready_o)
      else $error("bus active in reset");
   a_wake_hold: assert property (
      $rose(pins_o.rst_n) |-> !req_ready_o [*3]) else $error("ready during wake-up");
   // Address and data must not move at the data capture edge
   a_data_edge: assert property (
      $rose(pins_o.we_n) |-> !pins_o.ce_n && dq_oe_o && $stable(pins_o.addr) && $stable(dq_o))
      else $error("write data edge unstable");
   a_read_wait: assert property (
      $fell(pins_o.oe_n) |-> !rdata_valid_o [*2] ##[1:6] rdata_valid_o)
      else $error("read answer out of window");
   a_reselect_full: assert property (
      $fell(pins_o.ce_n) && pins_o.we_n |-> !rdata_valid_o [*4]) else $error("short random read");
   a_protect_follow: assert property (
      !$past(sys_rst_i) |-> pins_o.wp_n == !$past(wr_protect_i)) else $error("protect pin lag");
endmodule

// [verif/nfhc_flash_model.sv]
// Behavioural two-die NOR flash on the far side of the host bus
`timescale 1ns/1ps
module nfhc_flash_model #(
   parameter int          BUSY_CYC   = 6,
   parameter logic [15:0] START_CODE = 16'h0030
) (
   input  wire logic                 clk_i,
   input  wire nfhc_pkg::nfhc_pins_t pins_i,
   input  wire logic [15:0]          dq_i,
   input  wire logic                 dq_oe_i,
   input  wire logic                 slow_i,
   output logic [15:0]               dq_o,
   output logic                      ready_busy_n_o
);
   logic [26:0] cap_addr = '0;
   logic [15:0] cap_data = '0;
   logic [15:0] pat      = 16'h5a5a;
   logic        wr_act   = 1'b0;
   logic        late     = 1'b0;
   int          busy     = 0;
   int          viol     = 0;
   realtime     t_low    = 0.0;
   // Block index folded into the offset so die and block errors show
   function automatic logic [15:0] word(input logic [26:0] a);
      return a[15:0] ^ {5'h00, a[26:16]};
   endfunction
   // Slow mode hides the data for the first cycle after select falls
   always @(posedge clk_i) begin
      pat  <= ~pat;
      late <= slow_i && pins_i.ce_n;
   end
   // Floating pins show a changing pattern, never the last word
   assign dq_o = (!pins_i.ce_n && !pins_i.oe_n && pins_i.rst_n && !late) ? word(pins_i.addr) : pat;
   always @(negedge pins_i.ce_n or negedge pins_i.we_n)
      if (!pins_i.ce_n && !pins_i.we_n && pins_i.rst_n) begin
         cap_addr = pins_i.addr;
         wr_act   = 1'b1;
         t_low    = $realtime;
      end
   // Data taken at the first rising strobe; strobes under 3 ns are ignored
   always @(posedge pins_i.ce_n or posedge pins_i.we_n)
      if (wr_act && $realtime - t_low >= 3.0) begin
         cap_data = dq_i;
         wr_act   = 1'b0;
         if (!pins_i.oe_n || !pins_i.wp_n || !dq_oe_i) viol++;
         if (dq_i == START_CODE) busy = BUSY_CYC;
      end
   // Select high does not stop the operation; reset low aborts it
   always @(posedge clk_i)
      if (!pins_i.rst_n) begin
         busy   = 0;
         wr_act = 1'b0;
      end else if (busy > 0) busy--;
   assign ready_busy_n_o = (busy == 0);
endmodule

// [verif/nfhc_host_tb.sv]
// Self-checking bench for the NOR flash host controller
`timescale 1ns/1ps
module nfhc_host_tb;
   logic                 clk_i = 1'b0, sys_rst_i = 1'b1, clk_en_i = 1'b1, slow = 1'b0;
   logic                 req_valid_i = 1'b0, wr_protect_i = 1'b0;
   nfhc_pkg::nfhc_req_t  req_i = '0;
   nfhc_pkg::nfhc_pins_t pins_o;
   logic                 req_ready_o, rdata_valid_o, flash_busy_o, dq_oe_o, rb_n;
   logic [15:0]          rdata_o, dq_o, fl_dq;
   int                   errors = 0, n_compared = 0, cyc = 0;
   always #50 clk_i = ~clk_i;
   nfhc_host #(.RST_LOW_CYC(300), .RST_RD_CYC(4), .RST_WR_CYC(4)) i_dut (.clk_i(clk_i),
      .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .req_i(req_i), .req_valid_i(req_valid_i),
      .req_ready_o(req_ready_o), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
      .wr_protect_i(wr_protect_i), .flash_busy_o(flash_busy_o), .pins_o(pins_o),
      .dq_i(fl_dq), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .ready_busy_n_i(rb_n));
   nfhc_flash_model #(.BUSY_CYC(40)) i_flash (.clk_i(clk_i), .pins_i(pins_o), .dq_i(dq_o),
      .dq_oe_i(dq_oe_o),
      .slow_i(slow), .dq_o(fl_dq), .ready_busy_n_o(rb_n));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      if (errors == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Hold the request until ready is seen, then release after the taking edge
   task automatic issue(input nfhc_pkg::nfhc_op_t op, input logic [26:0] a, input logic [15:0] d);
      @(negedge clk_i);
      req_i       = '{op, a, d};
      req_valid_i = 1'b1;
      for (int k = 0; k < 1000 && req_ready_o !== 1'b1; k++) @(negedge clk_i);
      chk(req_ready_o, 1);
      @(negedge clk_i);
      req_valid_i = 1'b0;
      cyc         = 0;
   endtask
   task automatic rd(input logic [26:0] a, input int lim);
      issue(nfhc_pkg::NFHC_OP_READ, a, 16'h0000);
      while (rdata_valid_o !== 1'b1 && cyc < 20) begin
         @(negedge clk_i);
         cyc++;
      end
      chk(rdata_o, i_flash.word(a));
      chk(cyc <= lim, 1);
   endtask
   // Die edges, slow answers and a page hit after a random read
   task automatic s_reads;
      logic [26:0] tbl [4] = '{27'h0000000, 27'h3ffffff, 27'h4000000, 27'h7fffff0};
      foreach (tbl[i]) begin
         slow = i[0];
         rd(tbl[i], 8);
      end
      rd(27'h7fffff5, 3);
   endtask
   // Command write, then a busy operation cut short by a reset request
   task automatic s_write;
      issue(nfhc_pkg::NFHC_OP_WRITE, 27'h0000555, 16'h00aa);
      repeat (4) @(negedge clk_i);
      chk(i_flash.cap_addr, 27'h0000555);
      chk(i_flash.cap_data, 16'h00aa);
      slow = 1'b1;
      rd(27'h7fffff6, 8);
      issue(nfhc_pkg::NFHC_OP_WRITE, 27'h0000aaa, 16'h0030);
      repeat (4) @(negedge clk_i);
      chk(flash_busy_o, 1);
      issue(nfhc_pkg::NFHC_OP_RESET, 27'h0000000, 16'h0000);
      repeat (5) @(negedge clk_i);
      chk(flash_busy_o, 0);
      chk(i_flash.viol, 0);
      rd(27'h0012345, 8);
   endtask
   task automatic s_protect;
      wr_protect_i = 1'b1;
      repeat (2) @(negedge clk_i);
      chk(pins_o.wp_n, 0);
      clk_en_i = 1'b0;
      @(negedge clk_i);
      chk(req_ready_o, 0);
      clk_en_i     = 1'b1;
      wr_protect_i = 1'b0;
      repeat (2) @(negedge clk_i);
      chk(pins_o.wp_n, 1);
   endtask
   initial begin
      #(5000 * 100);
      errors++;
      wrap_up();
   end
   initial begin
      repeat (10) @(negedge clk_i);
      chk({pins_o.ce_n, pins_o.oe_n, pins_o.we_n, pins_o.rst_n, dq_oe_o, req_ready_o}, 6'h38);
      sys_rst_i = 1'b0;
      s_reads();
      s_write();
      s_protect();
      wrap_up();
   end
endmodule
bind nfhc_host nfhc_host_props #(.DATA_W(DATA_W)) i_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
   .req_ready_o(req_ready_o), .rdata_valid_o(rdata_valid_o), .wr_protect_i(wr_protect_i),
   .pins_o(pins_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o));
